//--- common/psesel_map.vh
// event codes, unit masks and field constants for the stall event selector
// Summary of operation
// - D1H/04H counts each decoded stack-pointer instruction
// - stack ops update delta tracker, no micro-op
// - D1H/08H counts each stack-pointer delta sync
// - D2H/01H counts execution stall cycles incl. flags
// - flag stall needs partial write then unmodified-flag read
// - D2H/02H counts partial-register latency stall cycles
// - D2H/04H counts reorder-buffer read-port stall cycles
// - blocked micro-ops retry next cycle, recounted
// - D2H/08H counts serialisation scoreboard stall cycles
// - D2H/0FH counts read-port, partial-register, flag and status-word stall cycles, not scoreboard
// - D4H/01H counts segment rename resource stall cycles
// - second update to unretired renamed segment stalls
// - D5H/01H counts each ES segment rename
`ifndef PSESEL_MAP_VH
`define PSESEL_MAP_VH

// ----------------------------------------------------------------
// event numbers
// ----------------------------------------------------------------
`define PSESEL_EVT_DECODE 8'hD1
`define PSESEL_EVT_ALLOC 8'hD2
`define PSESEL_EVT_SEG_STALL 8'hD4
`define PSESEL_EVT_ES_RENAME 8'hD5

// ----------------------------------------------------------------
// unit masks
// ----------------------------------------------------------------
`define PSESEL_UM_FOLD 8'h04
`define PSESEL_UM_SYNC 8'h08
`define PSESEL_UM_FLAGS 8'h01
`define PSESEL_UM_PARTIAL 8'h02
`define PSESEL_UM_ROB_PORT 8'h04
`define PSESEL_UM_SCOREBOARD 8'h08
`define PSESEL_UM_ANY 8'h0F
`define PSESEL_UM_SEG_STALL 8'h01
`define PSESEL_UM_ES_RENAME 8'h01

// ----------------------------------------------------------------
// field widths and values
// ----------------------------------------------------------------
`define PSESEL_FLAG_W 6
`define PSESEL_FLAG_ALL 6'h3F
`define PSESEL_FLAG_NONE 6'h00
`define PSESEL_SEG_N 4
`define PSESEL_SEG_PEND_RST 4'h0
`define PSESEL_SEG_ES 2'h0
`define PSESEL_SP_W 32
`define PSESEL_DELTA_W 16
`define PSESEL_SP_RST 32'h00000000
`define PSESEL_DELTA_RST 16'h0000

`endif

//--- rtl/psesel_stack.v
// stack-pointer delta tracker with fold and sync event pulses
`timescale 1ns/1ps
`include "psesel_map.vh"

module psesel_stack (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire fold_i, // decoded stack instruction
  input wire [`PSESEL_DELTA_W-1:0] fold_delta_i, // its signed offset
  input wire sp_read_i, // uop reads stack pointer explicitly
  output wire fold_pulse_o, // one pulse per folded instruction
  output wire sync_pulse_o, // one pulse per delta sync
  output wire [`PSESEL_DELTA_W-1:0] delta_o, // stack_delta_tracker
  output wire [`PSESEL_SP_W-1:0] sp_o // stack_pointer_reg
);

  reg fold_pulse_q; // fold event flop
  reg sync_pulse_q; // sync event flop
  reg [`PSESEL_DELTA_W-1:0] delta_q; // stack_delta_tracker
  reg [`PSESEL_SP_W-1:0] sp_q; // stack_pointer_reg

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  wire sync_d; // a sync is only needed with a pending delta
  wire [`PSESEL_SP_W-1:0] delta_ext; // sign-extended delta
  wire [`PSESEL_DELTA_W-1:0] delta_base; // delta left after sync

  assign sync_d = sp_read_i & (delta_q != `PSESEL_DELTA_RST);
  assign delta_ext = {{(`PSESEL_SP_W-`PSESEL_DELTA_W)
    {delta_q[`PSESEL_DELTA_W-1]}}, delta_q};
  assign delta_base = sync_d ? `PSESEL_DELTA_RST : delta_q;

  // fold into tracker, no adjust micro-op; sync adds delta to sp
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fold_pulse_q <= 1'b0;
      sync_pulse_q <= 1'b0;
      delta_q <= `PSESEL_DELTA_RST;
      sp_q <= `PSESEL_SP_RST;
    end else if (ce_i) begin
      fold_pulse_q <= fold_i;
      sync_pulse_q <= sync_d;
      if (sync_d) begin
        sp_q <= sp_q + delta_ext;
      end
      if (fold_i) begin
        delta_q <= delta_base + fold_delta_i;
      end else begin
        delta_q <= delta_base;
      end
    end
  end

  // outputs come straight from the flops
  assign fold_pulse_o = fold_pulse_q;
  assign sync_pulse_o = sync_pulse_q;
  assign delta_o = delta_q;
  assign sp_o = sp_q;

endmodule // psesel_stack

//--- rtl/psesel_top.v
// event selection and increment logic for pipeline stall events
`timescale 1ns/1ps
`include "psesel_map.vh"

module psesel_top (
  input wire CLK_SYS_I,
  input wire RST_B_I,
  input wire CE_I,
  // event select
  input wire [7:0] EVT_SEL_I,
  input wire [7:0] UMASK_I,
  // decode stage
  input wire STACK_FOLD_I,
  input wire [15:0] STACK_DELTA_I,
  input wire SP_READ_I,
  // flag tracking
  input wire FLAG_WR_I,
  input wire [5:0] FLAG_WR_MASK_I,
  input wire FLAG_RD_I,
  input wire [5:0] FLAG_RD_MASK_I,
  input wire EXEC_STALL_OTHER_I,
  // allocation stall sources
  input wire PARTIAL_REG_STALL_I,
  input wire ROB_PORT_STALL_I,
  input wire SCOREBOARD_STALL_I,
  input wire FPSW_STALL_I,
  // segment rename
  input wire SEG_WR_I,
  input wire [1:0] SEG_WR_SEL_I,
  input wire SEG_RETIRE_I,
  input wire [1:0] SEG_RETIRE_SEL_I,
  // outputs
  output wire COUNT_INC_O,
  output wire SEG_STALL_O,
  output wire FLAG_STALL_O,
  output wire [31:0] SP_VALUE_O,
  output wire [15:0] SP_DELTA_O
);

  // ----------------------------------------------------------------
  // decoding helper
  // ----------------------------------------------------------------
  // true when the programmed pair equals one listed pair
  function sel_match;
    input [7:0] evt;
    input [7:0] um;
    input [7:0] evt_ref;
    input [7:0] um_ref;
    begin
      sel_match = (evt == evt_ref) && (um == um_ref);
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg count_inc_q; // single increment flop
  reg count_inc_d;
  reg seg_stall_q; // stall to front end
  reg flag_stall_q; // flag stall indication
  reg [5:0] flag_wr_mask_q; // flags written by last writer
  reg flag_partial_q; // last writer was partial
  reg flag_partial_d;
  reg [3:0] seg_pend_q; // renamed but not retired
  wire [3:0] seg_pend_d;
  wire [3:0] seg_wr_hit; // write to segment n
  wire [3:0] seg_ret_hit; // retire of segment n
  wire [3:0] seg_conflict; // second update to pending n
  wire seg_stall_d; // any conflict this cycle
  wire seg_accept; // write that is not stalled
  wire es_rename; // accepted write to ES
  wire flag_stall_d; // flag stall this cycle
  wire exec_stall; // execution stall, all causes
  wire alloc_any; // combined allocation stall
  wire fold_pulse; // from tracker
  wire sync_pulse; // from tracker
  wire [15:0] delta_w; // tracker value
  wire [31:0] sp_w; // stack pointer value

  // ----------------------------------------------------------------
  // stack delta tracker
  // ----------------------------------------------------------------
  psesel_stack u_stack (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .ce_i(CE_I),
    .fold_i(STACK_FOLD_I),
    .fold_delta_i(STACK_DELTA_I),
    .sp_read_i(SP_READ_I),
    .fold_pulse_o(fold_pulse),
    .sync_pulse_o(sync_pulse),
    .delta_o(delta_w),
    .sp_o(sp_w)
  );

  // ----------------------------------------------------------------
  // partial flag stall detection
  // ----------------------------------------------------------------
  // stall only if last writer was partial and reader
  // needs flags that writer left alone
  assign flag_stall_d = FLAG_RD_I & flag_partial_q &
    (|(FLAG_RD_MASK_I & ~flag_wr_mask_q));

  // partial means some but not all flags written
  always @* begin
    flag_partial_d = (FLAG_WR_MASK_I != `PSESEL_FLAG_ALL) &&
      (FLAG_WR_MASK_I != `PSESEL_FLAG_NONE);
  end

  // remember the most recent flag writer
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flag_wr_mask_q <= `PSESEL_FLAG_ALL;
      flag_partial_q <= 1'b0;
    end else if (CE_I) begin
      if (FLAG_WR_I) begin
        flag_wr_mask_q <= FLAG_WR_MASK_I;
        flag_partial_q <= flag_partial_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // combined stall terms
  // ----------------------------------------------------------------
  // flag stall is one of several execution stall causes
  assign exec_stall = flag_stall_d | EXEC_STALL_OTHER_I;
  // read port, partial register, flag and status word
  assign alloc_any = ROB_PORT_STALL_I | PARTIAL_REG_STALL_I |
    flag_stall_d | FPSW_STALL_I;

  // ----------------------------------------------------------------
  // segment rename tracking
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PSESEL_SEG_N; g = g + 1) begin : g_seg
      assign seg_wr_hit[g] = SEG_WR_I & (SEG_WR_SEL_I == g);
      assign seg_ret_hit[g] = SEG_RETIRE_I & (SEG_RETIRE_SEL_I == g);
      // renamed, not yet retired, second update arrives
      assign seg_conflict[g] = seg_wr_hit[g] & seg_pend_q[g] &
        ~seg_ret_hit[g];
      // set on accepted rename, clear on retire
      assign seg_pend_d[g] = (seg_pend_q[g] & ~seg_ret_hit[g]) |
        (seg_wr_hit[g] & ~seg_stall_d);
    end
  endgenerate

  // the front end holds the write while this is high
  assign seg_stall_d = |seg_conflict;
  assign seg_accept = SEG_WR_I & ~seg_stall_d;
  assign es_rename = seg_accept &
    (SEG_WR_SEL_I == `PSESEL_SEG_ES);

  // pending rename bits
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      seg_pend_q <= `PSESEL_SEG_PEND_RST;
    end else if (CE_I) begin
      seg_pend_q <= seg_pend_d;
    end
  end

  // ----------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------
  // level stalls count once per cycle; ROB port stalls
  // that persist on retry simply count again next cycle
  always @* begin
    count_inc_d = 1'b0; // unlisted pairs give nothing
    if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_DECODE,
        `PSESEL_UM_FOLD)) begin
      count_inc_d = fold_pulse;
    end else if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_DECODE,
        `PSESEL_UM_SYNC)) begin
      count_inc_d = sync_pulse;
    end else if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_ALLOC,
        `PSESEL_UM_FLAGS)) begin
      count_inc_d = exec_stall;
    end else if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_ALLOC,
        `PSESEL_UM_PARTIAL)) begin
      count_inc_d = PARTIAL_REG_STALL_I;
    end else if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_ALLOC,
        `PSESEL_UM_ROB_PORT)) begin
      count_inc_d = ROB_PORT_STALL_I;
    end else if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_ALLOC,
        `PSESEL_UM_SCOREBOARD)) begin
      count_inc_d = SCOREBOARD_STALL_I;
    end else if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_ALLOC,
        `PSESEL_UM_ANY)) begin
      count_inc_d = alloc_any;
    end else if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_SEG_STALL,
        `PSESEL_UM_SEG_STALL)) begin
      count_inc_d = seg_stall_d;
    end else if (sel_match(EVT_SEL_I, UMASK_I, `PSESEL_EVT_ES_RENAME,
        `PSESEL_UM_ES_RENAME)) begin
      count_inc_d = es_rename;
    end else begin
      count_inc_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output flops
  // ----------------------------------------------------------------
  // a single bit per cycle caps the rate at one increment
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      count_inc_q <= 1'b0;
      seg_stall_q <= 1'b0;
      flag_stall_q <= 1'b0;
    end else if (CE_I) begin
      count_inc_q <= count_inc_d;
      seg_stall_q <= seg_stall_d;
      flag_stall_q <= flag_stall_d;
    end
  end

  assign COUNT_INC_O = count_inc_q;
  assign SEG_STALL_O = seg_stall_q;
  assign FLAG_STALL_O = flag_stall_q;
  assign SP_VALUE_O = sp_w;
  assign SP_DELTA_O = delta_w;

endmodule // psesel_top

//--- verification/psesel_core_model.sv
// partner model: rename stage retiring renamed segment registers
`timescale 1ns/1ps
module psesel_core_model (
  input wire clk_i,
  input wire rst_b_i,
  input wire [3:0] lat_i, // retire latency, 1 is prompt
  input wire seg_wr_i, // segment update seen by the block
  input wire [1:0] seg_sel_i,
  output wire retire_o, // renamed value retires
  output wire [1:0] retire_sel_o
);
  reg [3:0] cnt_q; // cycles left until retire
  reg [1:0] sel_q; // segment in flight
  // start on an update while idle or while the last one retires
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 4'h0;
      sel_q <= 2'h0;
    end else if (seg_wr_i && cnt_q <= 4'h1) begin
      cnt_q <= lat_i;
      sel_q <= seg_sel_i;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign retire_o = cnt_q == 4'h1;
  // idle select is inverted so a stale value never matches
  assign retire_sel_o = retire_o ? sel_q : ~sel_q;
endmodule // psesel_core_model

//--- verification/psesel_properties.sv
// checker: port-level properties of the stall event selector
`timescale 1ns/1ps
module psesel_properties (
  input wire CLK_SYS_I, RST_B_I, CE_I,
  input wire [7:0] EVT_SEL_I, UMASK_I,
  input wire STACK_FOLD_I, SP_READ_I, FLAG_RD_I,
  input wire [15:0] STACK_DELTA_I, SP_DELTA_O,
  input wire PARTIAL_REG_STALL_I, ROB_PORT_STALL_I, FPSW_STALL_I,
  input wire SEG_WR_I, SEG_RETIRE_I,
  input wire [1:0] SEG_WR_SEL_I,
  input wire COUNT_INC_O, SEG_STALL_O, FLAG_STALL_O
);
  // decoded selections
  wire s_fold = EVT_SEL_I == 8'hD1 && UMASK_I == 8'h04;
  wire s_sync = EVT_SEL_I == 8'hD1 && UMASK_I == 8'h08;
  wire s_flg = EVT_SEL_I == 8'hD2 && UMASK_I == 8'h01;
  wire s_alc = EVT_SEL_I == 8'hD2 && (UMASK_I == 8'h02 ||
    UMASK_I == 8'h04 || UMASK_I == 8'h08);
  wire s_rob = EVT_SEL_I == 8'hD2 && UMASK_I == 8'h04;
  wire s_any = EVT_SEL_I == 8'hD2 && UMASK_I == 8'h0F;
  wire s_seg = EVT_SEL_I == 8'hD4 && UMASK_I == 8'h01;
  wire s_es = EVT_SEL_I == 8'hD5 && UMASK_I == 8'h01;
  wire lst = s_fold | s_sync | s_flg | s_alc | s_any | s_seg | s_es;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  property p_fold;
    s_fold && STACK_FOLD_I && CE_I ##1 s_fold |=> COUNT_INC_O; endproperty
  a_fold: assert property (p_fold) else $error("fold not counted");
  property p_delta; STACK_FOLD_I && !SP_READ_I && CE_I |=>
    SP_DELTA_O == $past(SP_DELTA_O) + $past(STACK_DELTA_I); endproperty
  a_delta: assert property (p_delta) else $error("delta wrong");
  property p_sync; s_sync && SP_READ_I && SP_DELTA_O != 16'h0000 && CE_I
    ##1 s_sync |=> COUNT_INC_O; endproperty
  a_sync: assert property (p_sync) else $error("sync not counted");
  property p_flg; $past(s_flg) && FLAG_STALL_O |-> COUNT_INC_O; endproperty
  a_flg: assert property (p_flg) else $error("flag stall missed");
  property p_flgrd; FLAG_STALL_O |-> $past(FLAG_RD_I); endproperty
  a_flgrd: assert property (p_flgrd) else $error("stall, no reader");
  property p_rob; (s_rob && ROB_PORT_STALL_I && CE_I) [*2] |=>
    $past(COUNT_INC_O) && COUNT_INC_O; endproperty
  a_rob: assert property (p_rob) else $error("retry not recounted");
  property p_any; s_any && CE_I && (ROB_PORT_STALL_I ||
    PARTIAL_REG_STALL_I || FPSW_STALL_I) |=> COUNT_INC_O; endproperty
  a_any: assert property (p_any) else $error("any stall missed");
  property p_segs; (SEG_WR_I && !SEG_RETIRE_I && CE_I) ##1 (SEG_WR_I &&
    !SEG_RETIRE_I && SEG_WR_SEL_I == $past(SEG_WR_SEL_I)) |=> SEG_STALL_O;
  endproperty
  a_segs: assert property (p_segs) else $error("no seg stall");
  property p_es; s_es && SEG_WR_I && SEG_WR_SEL_I == 2'h0 && CE_I |=>
    COUNT_INC_O != SEG_STALL_O; endproperty
  a_es: assert property (p_es) else $error("es rename count");
  property p_none; !lst ##1 !lst |=> !COUNT_INC_O; endproperty
  a_none: assert property (p_none) else $error("stray increment");
  c_fold: cover property (s_fold && STACK_FOLD_I ##2 COUNT_INC_O);
  c_seg: cover property (s_seg && SEG_STALL_O);
  c_rob: cover property (s_rob && ROB_PORT_STALL_I [*2]);
endmodule // psesel_properties

bind psesel_top psesel_properties u_props (.*);

//--- verification/tb_pipeline_stall_event_select.sv
// self-checking testbench for the stall event selector
`timescale 1ns/1ps
module tb_pipeline_stall_event_select;
  reg clk, rst_b, ce, fold, spr, fwr, frd, oth, swr;
  reg [15:0] d0; // tracker value before a hold
  reg [7:0] evt, um; // event select
  reg [15:0] dlt; // fold offset
  reg [5:0] fwm, frm; // flag masks
  reg [3:0] stl, lat; // stall sources, partner latency
  reg [1:0] ssel; // segment select
  wire inc, sstl, fstl, ret;
  wire [1:0] rsel;
  wire [31:0] spv;
  wire [15:0] spd;
  integer errors = 0, n_checks = 0, cnt = 0, b, i;
  psesel_top u_dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .CE_I(ce),
    .EVT_SEL_I(evt), .UMASK_I(um), .STACK_FOLD_I(fold),
    .STACK_DELTA_I(dlt), .SP_READ_I(spr), .FLAG_WR_I(fwr),
    .FLAG_WR_MASK_I(fwm), .FLAG_RD_I(frd), .FLAG_RD_MASK_I(frm),
    .EXEC_STALL_OTHER_I(oth), .PARTIAL_REG_STALL_I(stl[0]),
    .ROB_PORT_STALL_I(stl[1]), .SCOREBOARD_STALL_I(stl[2]),
    .FPSW_STALL_I(stl[3]), .SEG_WR_I(swr), .SEG_WR_SEL_I(ssel),
    .SEG_RETIRE_I(ret), .SEG_RETIRE_SEL_I(rsel), .COUNT_INC_O(inc),
    .SEG_STALL_O(sstl), .FLAG_STALL_O(fstl), .SP_VALUE_O(spv),
    .SP_DELTA_O(spd));
  psesel_core_model u_core (.clk_i(clk), .rst_b_i(rst_b), .lat_i(lat),
    .seg_wr_i(swr), .seg_sel_i(ssel), .retire_o(ret),
    .retire_sel_o(rsel));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // count increments mid-cycle, where the output has settled
  always @(negedge clk) begin
    if (inc === 1'b1) begin
      cnt <= cnt + 1;
    end else if (inc !== 1'b0) begin
      errors = errors + 1;
      $display("mismatch at %0t got %h exp %h", $time, inc, 1'b0);
    end
  end
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task sel(input [7:0] e, input [7:0] u);
    evt = e;
    um = u;
    b = cnt;
  endtask
  task t_fold;
    sel(8'hD1, 8'h04);
    fold = 1'b1;
    dlt = 16'h0004;
    tick(3);
    fold = 1'b0;
    tick(4);
    chk(cnt - b, 3);
    chk(spd, 16'h000C);
    chk(spv, 32'h00000000);
    $display("test fold done");
  endtask
  task t_sync;
    sel(8'hD1, 8'h08);
    spr = 1'b1;
    tick(1);
    spr = 1'b0;
    fold = 1'b1;
    dlt = 16'hFFF0;
    tick(1);
    fold = 1'b0;
    spr = 1'b1;
    tick(2);
    spr = 1'b0;
    tick(4);
    chk(cnt - b, 2);
    chk(spv, 32'hFFFFFFFC);
    $display("test sync done");
  endtask
  task t_flag;
    sel(8'hD2, 8'h01);
    fwr = 1'b1;
    fwm = 6'h01;
    tick(1);
    fwr = 1'b0;
    frd = 1'b1;
    frm = 6'h02;
    tick(2);
    frm = 6'h01;
    tick(1);
    frd = 1'b0;
    fwr = 1'b1;
    fwm = 6'h3F;
    tick(1);
    fwr = 1'b0;
    frd = 1'b1;
    frm = 6'h02;
    tick(1);
    frd = 1'b0;
    oth = 1'b1;
    tick(1);
    oth = 1'b0;
    tick(3);
    chk(cnt - b, 3);
    $display("test flag done");
  endtask
  task t_stalls;
    integer s;
    for (i = 0; i < 4; i = i + 1) begin
      sel(8'hD2, i == 3 ? 8'h0F : 8'h02 << i);
      for (s = 0; s < 4; s = s + 1) begin
        stl = 4'h1 << s;
        tick(2);
      end
      stl = 4'h0;
      tick(3);
      chk(cnt - b, i == 3 ? 6 : 2);
    end
    $display("test stalls done");
  endtask
  task t_seg(input [7:0] e, input [3:0] l, input integer n);
    sel(e, 8'h01);
    lat = l;
    ssel = 2'h0;
    swr = 1'b1;
    tick(2);
    swr = 1'b0;
    tick(6);
    chk(cnt - b, n);
    $display("test segment done");
  endtask
  task t_none;
    for (i = 0; i < 3; i = i + 1) begin
      sel(i == 1 ? 8'hD3 : 8'hD2 + i[7:0] * 8'h03, i == 2 ? 8'h02 : 8'h10);
      stl = 4'hF;
      {oth, fold, swr} = 3'h7;
      tick(3);
      stl = 4'h0;
      {oth, fold, swr} = 3'h0;
      tick(4);
      chk(cnt - b, 0);
    end
    $display("test unlisted done");
  endtask
  task t_hold;
    sel(8'hD2, 8'h02);
    d0 = spd;
    ce = 1'b0;
    stl = 4'h1;
    fold = 1'b1;
    tick(3);
    chk(cnt - b, 0);
    chk(spd, d0);
    ce = 1'b1;
    fold = 1'b0;
    tick(1);
    stl = 4'h0;
    tick(3);
    chk(cnt - b, 1);
    $display("test hold done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {rst_b, fold, spr, fwr, frd, oth, swr} = 7'h00;
    {evt, um, dlt, fwm, frm, stl, ssel} = 50'h0;
    ce = 1'b1;
    lat = 4'h3;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    t_fold;
    t_sync;
    t_flag;
    t_stalls;
    t_seg(8'hD5, 4'h3, 1);
    t_seg(8'hD4, 4'h3, 1);
    t_seg(8'hD5, 4'h1, 2);
    t_none;
    t_hold;
    give_verdict;
  end
  // watchdog well beyond the roughly 140 cycles needed
  initial begin
    #20000;
    errors = errors + 1;
    give_verdict;
  end
endmodule // tb_pipeline_stall_event_select
